// ===== testbench/clhr_core_monitor.sv
`timescale 1ns/1ps

module clhr_core_monitor (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       clk_en,
    input wire logic       register_select_line,
    input wire logic       read_not_write,
    input wire logic       enable_strobe,
    input wire logic [7:0] bus_line_in,
    input wire logic [7:0] bus_line_out,
    input wire logic       bus_line_oe,
    input wire logic       scan_line,
    input wire logic [3:0] scan_col,
    input wire logic [2:0] scan_row,
    input wire logic [4:0] glyph_pixels
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst || !clk_en);

    logic        strobe_q;
    logic [2:0]  rs_hist;
    logic        wrote;
    logic        idle_seen;
    logic [11:0] busy_left;
    logic        stat_vis;
    logic        wr_fall;

    // status byte on the bus, write strobe just ended
    assign stat_vis = bus_line_oe && !rs_hist[2];
    assign wr_fall  = strobe_q && !enable_strobe && !read_not_write;

    // pin history and a lower bound of the busy window after an idle write
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            strobe_q  <= 1'b0;
            rs_hist   <= 3'h0;
            wrote     <= 1'b0;
            idle_seen <= 1'b0;
            busy_left <= 12'h000;
        end
        else
        begin
            strobe_q <= enable_strobe;
            rs_hist  <= {rs_hist[1:0], register_select_line};
            if (wr_fall)
            begin
                wrote     <= 1'b1;
                idle_seen <= 1'b0;
                // clear has its own busy time, CLEAR_CYCLES, longer than the others by default
                if (idle_seen && (register_select_line || bus_line_in != 8'h01))
                    busy_left <= 12'hED8; // 3800, safely inside the busy time
            end
            else
            begin
                if (stat_vis && !bus_line_out[7])
                    idle_seen <= 1'b1;
                if (busy_left != 12'h000)
                    busy_left <= busy_left - 12'h001;
            end
        end
    end

    a_oe_rise: assert property ($rose(enable_strobe) && read_not_write
        |-> ##3 bus_line_oe)
        else $error("bus drive late after read strobe");
    a_oe_drop: assert property ($fell(enable_strobe) |-> ##3 !bus_line_oe)
        else $error("bus drive held after strobe end");
    a_oe_cause: assert property (bus_line_oe
        |-> $past(enable_strobe, 3) && $past(read_not_write, 3))
        else $error("bus driven without a read strobe");
    a_write_quiet: assert property ((!read_not_write) [*4] |-> !bus_line_oe)
        else $error("bus driven during a write");
    a_read_hold: assert property (bus_line_oe && $past(bus_line_oe)
        && rs_hist[2] && rs_hist[1] |-> $stable(bus_line_out))
        else $error("read data moved while strobe high");
    a_first_status: assert property (!wrote && stat_vis |-> bus_line_out == 8'h00)
        else $error("status after reset not zero");
    a_busy_shown: assert property (busy_left != 12'h000 && stat_vis |-> bus_line_out[7])
        else $error("busy flag missing after a write");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |-> bus_line_out == 8'h00 && !bus_line_oe && glyph_pixels == 5'h00)
        else $error("outputs not cleared in reset");

    c_busy_read: cover property (stat_vis && bus_line_out[7]);
    c_data_read: cover property (bus_line_oe && rs_hist[2]);
    c_glyph_lit: cover property (glyph_pixels != 5'h00);
endmodule // clhr_core_monitor

bind clhr_core clhr_core_monitor i_clhr_core_monitor (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .register_select_line(register_select_line), .read_not_write(read_not_write),
    .enable_strobe(enable_strobe), .bus_line_in(bus_line_in), .bus_line_out(bus_line_out),
    .bus_line_oe(bus_line_oe), .scan_line(scan_line), .scan_col(scan_col),
    .scan_row(scan_row), .glyph_pixels(glyph_pixels)
);

// ===== testbench/clhr_host_model.sv
`timescale 1ns/1ps

module clhr_host_model (
    input  wire logic       core_clk,
    output logic            register_select_line,
    output logic            read_not_write,
    output logic            enable_strobe,
    output logic      [7:0] bus_line_in,
    input  wire logic [7:0] bus_line_out,
    input  wire logic       bus_line_oe,
    output logic            rd_seen,
    output logic      [7:0] rd_data
);
    logic [7:0] drv;
    logic       drv_on;

    // released bus shows the core's byte while it drives, otherwise the inverse of the last host byte, not a stale copy
    assign bus_line_in = drv_on ? drv : (bus_line_oe ? bus_line_out : ~drv);

    initial
    begin
        register_select_line = 1'b0;
        read_not_write       = 1'b1;
        enable_strobe        = 1'b0;
        drv                  = 8'h00;
        drv_on               = 1'b0;
        rd_seen              = 1'b0;
        rd_data              = 8'h00;
    end

    // one strobe cycle, six clocks high and six low, all qualifiers held
    task automatic access(input logic rs, input logic rd, input logic [7:0] wdata,
                          input logic note, output logic [7:0] rdata);
        @(posedge core_clk);
        register_select_line <= rs;
        read_not_write       <= rd;
        drv                  <= wdata;
        drv_on               <= !rd;
        enable_strobe        <= 1'b1;
        repeat (6) @(posedge core_clk);
        rdata = bus_line_out; // read data taken while strobe high
        rd_seen       <= rd && note;
        rd_data       <= bus_line_out;
        enable_strobe <= 1'b0; // write taken at this falling edge
        @(posedge core_clk);
        rd_seen <= 1'b0;
        repeat (5) @(posedge core_clk);
        drv_on         <= 1'b0;
        read_not_write <= 1'b1;
    endtask
endmodule // clhr_host_model

// ===== testbench/tb_char_lcd_host_register_ram_access.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module tb_char_lcd_host_register_ram_access;
    logic       core_clk;
    logic       rst;
    logic       clk_en;
    logic       scan_line;
    logic [3:0] scan_col;
    logic [2:0] scan_row;
    logic       pix_seen;
    wire        register_select_line;
    wire        read_not_write;
    wire        enable_strobe;
    wire  [7:0] bus_line_in;
    wire  [7:0] bus_line_out;
    wire        bus_line_oe;
    wire  [4:0] glyph_pixels;
    wire        rd_seen;
    wire  [7:0] rd_data;
    int         err_count = 0;
    int         compares  = 0;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h3A16;
    logic [7:0] d0, d1, d2, row, v;

    clhr_core #(.CLEAR_CYCLES(20)) i_clhr_core (
        .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .register_select_line(register_select_line), .read_not_write(read_not_write),
        .enable_strobe(enable_strobe), .bus_line_in(bus_line_in), .bus_line_out(bus_line_out),
        .bus_line_oe(bus_line_oe), .scan_line(scan_line), .scan_col(scan_col),
        .scan_row(scan_row), .glyph_pixels(glyph_pixels));

    clhr_host_model i_clhr_host_model (
        .core_clk(core_clk), .register_select_line(register_select_line),
        .read_not_write(read_not_write), .enable_strobe(enable_strobe),
        .bus_line_in(bus_line_in), .bus_line_out(bus_line_out), .bus_line_oe(bus_line_oe),
        .rd_seen(rd_seen), .rd_data(rd_data));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // xorshift source for data bytes
    task automatic rnd(output logic [7:0] r);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        r = seed[7:0];
    endtask

    // status polling until the busy bit clears, bounded
    task automatic poll();
        int n;
        logic [7:0] s;
        n = 0;
        s = 8'h80;
        while (s[7] && n < 600)
        begin
            i_clhr_host_model.access(1'b0, 1'b1, 8'h00, 1'b0, s);
            n++;
        end
        if (s[7])
        begin
            err_count++;
            $display("unexpected at %0t: busy never cleared", $time);
        end
    endtask

    // bus operations, each followed by a busy poll where one is due
    task automatic cmd(input logic [7:0] c);
        i_clhr_host_model.access(1'b0, 1'b0, c, 1'b0, v);
        poll();
    endtask

    task automatic wr(input logic [7:0] d);
        i_clhr_host_model.access(1'b1, 1'b0, d, 1'b0, v);
        poll();
    endtask

    task automatic rd_expect(input logic [7:0] e);
        exp_q.push_back(e);
        i_clhr_host_model.access(1'b1, 1'b1, 8'h00, 1'b1, v);
        poll();
    endtask

    task automatic st_expect(input logic [7:0] e);
        exp_q.push_back(e);
        i_clhr_host_model.access(1'b0, 1'b1, 8'h00, 1'b1, v);
    endtask

    task automatic pix_expect(input logic ln, input logic [3:0] col, input logic [4:0] e);
        @(posedge core_clk);
        scan_line <= ln;
        scan_col  <= col;
        scan_row  <= 3'h0;
        repeat (2) @(posedge core_clk);
        exp_q.push_back({3'h0, e});
        pix_seen <= 1'b1;
        @(posedge core_clk);
        pix_seen <= 1'b0;
    endtask

    // result watcher: oldest note against each observed result
    always @(posedge core_clk)
    begin
        if (rd_seen || pix_seen)
        begin
            if (exp_q.size() == 0)
            begin
                err_count++;
                $display("unexpected at %0t: result with no note", $time);
            end
            else
            begin
                v = exp_q.pop_front();
                `CHK((rd_seen ? rd_data : {3'h0, glyph_pixels}), v)
            end
        end
    end

    task automatic complete_run();
        $display("err_count=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (95000) @(posedge core_clk);
        err_count++;
        $display("unexpected at %0t: run did not finish", $time);
        complete_run();
    end

    // main sequence
    initial
    begin
        rst       = 1'b1;
        clk_en    = 1'b1;
        scan_line = 1'b0;
        scan_col  = 4'h0;
        scan_row  = 3'h0;
        pix_seen  = 1'b0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rnd(d0);
        rnd(d1);
        rnd(d2);
        rnd(row);
        st_expect(8'h00);
        cmd(8'h85);
        st_expect(8'h05);
        wr(d0);
        wr(d1);
        st_expect(8'h07);
        cmd(8'h85);
        rd_expect(d0);
        rd_expect(d1);
        st_expect(8'h07);
        cmd(8'h04);
        wr(d2);
        st_expect(8'h06);
        cmd(8'h87);
        rd_expect(d2);
        // write issued while busy must be dropped
        i_clhr_host_model.access(1'b0, 1'b0, 8'h90, 1'b0, v);
        i_clhr_host_model.access(1'b1, 1'b0, d0, 1'b0, v);
        poll();
        st_expect(8'h10);
        rd_expect(clhr_pkg::BLANK_CODE);
        // custom glyph: rows first, then the code that shows it
        cmd(8'h06);
        cmd(8'h48);
        st_expect(8'h08);
        wr(row);
        st_expect(8'h09);
        cmd(8'h80);
        wr(8'h09);
        cmd(8'h0C);
        pix_expect(1'b0, 4'h0, row[4:0]);
        cmd(8'h1C);
        pix_expect(1'b0, 4'h1, row[4:0]);
        // clear refills blanks and homes the pointer
        cmd(8'h01);
        st_expect(8'h00);
        cmd(8'h80);
        rd_expect(clhr_pkg::BLANK_CODE);
        repeat (4) @(posedge core_clk);
        complete_run();
    end
endmodule // tb_char_lcd_host_register_ram_access

// ===== verilog/clhr_core.sv
`timescale 1ns/1ps

module clhr_core #(
    parameter int unsigned CLEAR_CYCLES = clhr_pkg::CLEAR_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic       register_select_line,
    input  wire logic       read_not_write,
    input  wire logic       enable_strobe,
    input  wire logic [7:0] bus_line_in,
    output logic      [7:0] bus_line_out,
    output logic            bus_line_oe,
    input  wire logic       scan_line,
    input  wire logic [3:0] scan_col,
    input  wire logic [2:0] scan_row,
    output logic      [4:0] glyph_pixels
);

    // pin synchronisers
    logic       e_meta;
    logic       e_sync;
    logic       e_prev;
    logic       rs_meta;
    logic       rs_sync;
    logic       rw_meta;
    logic       rw_sync;
    logic [7:0] bus_meta;
    logic [7:0] bus_sync;

    // control state
    clhr_pkg::clhr_state_type state;
    logic [clhr_pkg::BUSY_CNT_W-1:0] busy_cnt;
    logic       fetch_pending;
    logic [6:0] ram_pointer;
    logic       glyph_sel;
    logic       dir_inc;
    logic       entry_shift;
    logic       disp_on;
    logic       cursor_on;
    logic [5:0] win_off;
    logic [7:0] ram_transfer;

    // storage
    logic [7:0] character_code_memory [clhr_pkg::CHAR_DEPTH];
    logic [7:0] user_glyph_memory     [clhr_pkg::GLYPH_DEPTH];

    // maps a character address onto the 80-entry store
    function automatic logic [6:0] char_index(input logic [6:0] a);
        logic [5:0] lo;
        lo = (a[5:0] >= 6'(clhr_pkg::LINE_LEN)) ? 6'(a[5:0] - 6'(clhr_pkg::LINE_LEN))
                                                  : a[5:0];
        return a[6] ? 7'({1'b0, lo} + 7'(clhr_pkg::LINE_LEN)) : {1'b0, lo};
    endfunction

    // one pointer step; character space jumps between lines
    function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic g,
                                            input logic inc);
        logic [6:0] r;
        if (g)
            r = {1'b0, inc ? 6'(p[5:0] + 6'h01) : 6'(p[5:0] - 6'h01)};
        else if (inc)
            r = (p == clhr_pkg::LINE1_LAST) ? clhr_pkg::LINE2_BASE :
                (p == clhr_pkg::LINE2_LAST) ? 7'h00 : 7'(p + 7'h01);
        else
            r = (p == 7'h00)                ? clhr_pkg::LINE2_LAST :
                (p == clhr_pkg::LINE2_BASE) ? clhr_pkg::LINE1_LAST : 7'(p - 7'h01);
        return r;
    endfunction

    // window offset moved by one, wrapping over the 40-entry line
    function automatic logic [5:0] step_win(input logic [5:0] o, input logic right);
        logic [5:0] r;
        if (right)
            r = (o == 6'h00) ? clhr_pkg::WIN_LAST : 6'(o - 6'h01);
        else
            r = (o == clhr_pkg::WIN_LAST) ? 6'h00 : 6'(o + 6'h01);
        return r;
    endfunction

    // highest set bit other than bit 5 names the command
    function automatic clhr_pkg::clhr_cmd_type decode_cmd(input logic [7:0] c);
        clhr_pkg::clhr_cmd_type k;
        k = clhr_pkg::CLHR_CMD_NONE;
        if (c[7])
            k = clhr_pkg::CLHR_CMD_SET_CHAR;
        else if (c[6])
            k = clhr_pkg::CLHR_CMD_SET_GLYPH;
        else if (c[4])
            k = clhr_pkg::CLHR_CMD_SHIFT;
        else if (c[3])
            k = clhr_pkg::CLHR_CMD_DISPCTL;
        else if (c[2])
            k = clhr_pkg::CLHR_CMD_ENTRY;
        else if (c[1])
            k = clhr_pkg::CLHR_CMD_HOME;
        else if (c[0])
            k = clhr_pkg::CLHR_CMD_CLEAR;
        return k;
    endfunction

    // stand-in font; swap for the production dot table
    function automatic logic [4:0] fixed_glyph_table(input logic [7:0] code,
                                                     input logic [2:0] row);
        return (row == clhr_pkg::CURSOR_ROW) ? 5'h00 : 5'(code[4:0] ^ {code[7:5], 2'h0});
    endfunction

    // access decode, taken on the falling strobe edge
    wire        e_fall   = e_prev & ~e_sync;
    wire        idle     = (state == clhr_pkg::CLHR_IDLE);
    wire        internal_op_pending = ~idle;
    wire        instr_wr = e_fall & ~rs_sync & ~rw_sync & idle;
    wire        data_wr  = e_fall & rs_sync & ~rw_sync & idle;
    wire        data_rd  = e_fall & rs_sync & rw_sync & idle;
    clhr_pkg::clhr_cmd_type cmd;
    assign cmd = decode_cmd(bus_sync);
    wire        is_clear = instr_wr & (cmd == clhr_pkg::CLHR_CMD_CLEAR);
    wire        set_addr = instr_wr & ((cmd == clhr_pkg::CLHR_CMD_SET_CHAR) |
                                       (cmd == clhr_pkg::CLHR_CMD_SET_GLYPH));
    wire        cur_move = instr_wr & (cmd == clhr_pkg::CLHR_CMD_SHIFT) &
                           ~bus_sync[clhr_pkg::SHIFT_DISP_POS];
    wire        win_move = instr_wr & (cmd == clhr_pkg::CLHR_CMD_SHIFT) &
                           bus_sync[clhr_pkg::SHIFT_DISP_POS];
    wire        home     = instr_wr & (cmd == clhr_pkg::CLHR_CMD_HOME);
    wire [6:0]  ptr_idx  = char_index(ram_pointer);
    wire [5:0]  glyph_ix = ram_pointer[5:0];

    // memory byte at the pointer, from whichever store is selected
    wire [7:0]  ptr_data = glyph_sel ? user_glyph_memory[glyph_ix]
                                     : character_code_memory[ptr_idx];

    // panel scan: visible position to stored character
    wire [6:0]  col_sum  = 7'({3'h0, scan_col} + {1'b0, win_off});
    wire [6:0]  col_wrap = (col_sum >= 7'(clhr_pkg::LINE_LEN)) ?
                           7'(col_sum - 7'(clhr_pkg::LINE_LEN)) : col_sum;
    wire [6:0]  view_idx = scan_line ? 7'(col_wrap + 7'(clhr_pkg::LINE_LEN))
                                     : col_wrap;
    wire [7:0]  view_code = character_code_memory[view_idx];
    wire        user_code = (view_code[7:4] == 4'h0);
    wire [5:0]  view_gaddr = {view_code[2:0], scan_row};
    wire [4:0]  user_dots  = user_glyph_memory[view_gaddr][4:0];
    wire [4:0]  base_dots  = user_code ? user_dots
                                       : fixed_glyph_table(view_code, scan_row);
    wire        cursor_hit = cursor_on & ~glyph_sel & (ptr_idx == view_idx) &
                             (scan_row == clhr_pkg::CURSOR_ROW);
    wire [4:0]  next_pixels = disp_on ? (base_dots | {5{cursor_hit}}) : 5'h00;

    // two-stage synchronisers on every host bus pin input
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            {e_meta, e_sync, e_prev} <= 3'h0;
            {rs_meta, rs_sync, rw_meta, rw_sync} <= 4'h0;
            bus_meta <= 8'h00;
            bus_sync <= 8'h00;
        end
        else if (clk_en)
        begin
            e_meta   <= enable_strobe;
            e_sync   <= e_meta;
            e_prev   <= e_sync;
            rs_meta  <= register_select_line;
            rs_sync  <= rs_meta;
            rw_meta  <= read_not_write;
            rw_sync  <= rw_meta;
            bus_meta <= bus_line_in;
            bus_sync <= bus_meta;
        end
    end

    // internal operation sequencer, drives the busy flag
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state         <= clhr_pkg::CLHR_IDLE;
            busy_cnt      <= '0;
            fetch_pending <= 1'b0;
        end
        else if (clk_en)
        begin
            case (state)
                clhr_pkg::CLHR_IDLE:
                begin
                    if (instr_wr | data_wr | data_rd)
                    begin
                        state         <= clhr_pkg::CLHR_BUSY;
                        busy_cnt      <= is_clear ? clhr_pkg::BUSY_CNT_W'(CLEAR_CYCLES)
                                                  : clhr_pkg::BUSY_CNT_W'(clhr_pkg::OP_CYCLES);
                        fetch_pending <= set_addr | data_rd;
                    end
                end
                clhr_pkg::CLHR_BUSY:
                begin
                    busy_cnt <= busy_cnt - 1'b1;
                    if (busy_cnt <= clhr_pkg::BUSY_CNT_W'(1))
                        state <= fetch_pending ? clhr_pkg::CLHR_FETCH : clhr_pkg::CLHR_IDLE;
                end
                clhr_pkg::CLHR_FETCH:
                begin
                    state         <= clhr_pkg::CLHR_IDLE;
                    fetch_pending <= 1'b0;
                end
                default:
                begin
                    state <= clhr_pkg::CLHR_IDLE;
                end
            endcase
        end
    end

    // pointer, memory select and window offset
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ram_pointer <= 7'h00;
            glyph_sel   <= 1'b0;
            win_off     <= 6'h00;
        end
        else if (clk_en)
        begin
            if (is_clear | home)
            begin
                ram_pointer <= 7'h00;
                glyph_sel   <= 1'b0;
                win_off     <= 6'h00;
            end
            else if (set_addr)
            begin
                glyph_sel   <= ~bus_sync[7];
                ram_pointer <= bus_sync[7] ? bus_sync[6:0]
                                           : {1'b0, bus_sync[5:0]};
            end
            else if (cur_move)
                ram_pointer <= step_ptr(ram_pointer, glyph_sel,
                                        bus_sync[clhr_pkg::SHIFT_RIGHT_POS]);
            else if (win_move)
                win_off <= step_win(win_off, bus_sync[clhr_pkg::SHIFT_RIGHT_POS]);
            else if (data_wr | data_rd)
            begin
                ram_pointer <= step_ptr(ram_pointer, glyph_sel, dir_inc);
                if (data_wr & entry_shift & ~glyph_sel)
                    win_off <= step_win(win_off, ~dir_inc);
            end
        end
    end

    // mode bits written by entry and display commands
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            dir_inc     <= clhr_pkg::DIR_INC_RESET;
            entry_shift <= clhr_pkg::ENTRY_SH_RESET;
            disp_on     <= clhr_pkg::DISP_ON_RESET;
            cursor_on   <= clhr_pkg::CURSOR_RESET;
        end
        else if (clk_en)
        begin
            if (is_clear)
                dir_inc <= 1'b1;
            else if (instr_wr & (cmd == clhr_pkg::CLHR_CMD_ENTRY))
            begin
                dir_inc     <= bus_sync[clhr_pkg::ENTRY_DIR_POS];
                entry_shift <= bus_sync[clhr_pkg::ENTRY_SHIFT_POS];
            end
            if (instr_wr & (cmd == clhr_pkg::CLHR_CMD_DISPCTL))
            begin
                disp_on   <= bus_sync[clhr_pkg::DISP_ON_POS];
                cursor_on <= bus_sync[clhr_pkg::CURSOR_ON_POS];
            end
        end
    end

    // transfer register: host writes, prefetch after address or read
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ram_transfer <= 8'h00;
        else if (clk_en)
        begin
            if (data_wr)
                ram_transfer <= bus_sync;
            else if (state == clhr_pkg::CLHR_FETCH)
                ram_transfer <= ptr_data;
        end
    end

    // character store: clear fills blanks, data write stores a code
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < clhr_pkg::CHAR_DEPTH; i++)
                character_code_memory[i] <= clhr_pkg::BLANK_CODE;
        end
        else if (clk_en)
        begin
            if (is_clear)
            begin
                for (int i = 0; i < clhr_pkg::CHAR_DEPTH; i++)
                    character_code_memory[i] <= clhr_pkg::BLANK_CODE;
            end
            else if (data_wr & ~glyph_sel)
                character_code_memory[ptr_idx] <= bus_sync;
        end
    end

    // user glyph store, all eight bits kept as general storage
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < clhr_pkg::GLYPH_DEPTH; i++)
                user_glyph_memory[i] <= 8'h00;
        end
        else if (clk_en & data_wr & glyph_sel)
            user_glyph_memory[glyph_ix] <= bus_sync;
    end

    // bus drive while the strobe is high on a read, registered pixel row
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_line_out <= 8'h00;
            bus_line_oe  <= 1'b0;
            glyph_pixels <= 5'h00;
        end
        else if (clk_en)
        begin
            bus_line_oe  <= e_sync & rw_sync;
            bus_line_out <= rs_sync ? ram_transfer
                                    : {internal_op_pending, ram_pointer};
            glyph_pixels <= next_pixels;
        end
    end

endmodule // clhr_core

// ===== verilog/clhr_pkg.sv
package clhr_pkg;

    // timing of internal operations
    localparam int CLK_PERIOD_NS = 10;
    localparam int OP_TIME_NS    = 39000;
    localparam int OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_TIME_NS = 1530000;
    localparam int CLEAR_CYCLES  = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_CNT_W    = 18;

    // memory geometry
    localparam int CHAR_DEPTH  = 80;
    localparam int LINE_LEN    = 40;
    localparam int VISIBLE     = 16;
    localparam int GLYPH_DEPTH = 64;

    // pointer wrap points and fill values
    localparam logic [6:0] LINE2_BASE = 7'h40;
    localparam logic [6:0] LINE1_LAST = 7'h27;
    localparam logic [6:0] LINE2_LAST = 7'h67;
    localparam logic [5:0] WIN_LAST   = 6'h27;
    localparam logic [7:0] BLANK_CODE = 8'h20;
    localparam logic [2:0] CURSOR_ROW = 3'h7;

    // field positions inside command bytes
    localparam int ENTRY_DIR_POS   = 1;
    localparam int ENTRY_SHIFT_POS = 0;
    localparam int DISP_ON_POS     = 2;
    localparam int CURSOR_ON_POS   = 1;
    localparam int SHIFT_DISP_POS  = 3;
    localparam int SHIFT_RIGHT_POS = 2;

    // reset values of mode bits
    localparam logic DIR_INC_RESET  = 1'b1;
    localparam logic ENTRY_SH_RESET = 1'b0;
    localparam logic DISP_ON_RESET  = 1'b0;
    localparam logic CURSOR_RESET   = 1'b0;

    typedef enum {
        CLHR_IDLE,
        CLHR_BUSY,
        CLHR_FETCH
    } clhr_state_type;

    typedef enum {
        CLHR_CMD_NONE,
        CLHR_CMD_CLEAR,
        CLHR_CMD_HOME,
        CLHR_CMD_ENTRY,
        CLHR_CMD_DISPCTL,
        CLHR_CMD_SHIFT,
        CLHR_CMD_SET_GLYPH,
        CLHR_CMD_SET_CHAR
    } clhr_cmd_type;

endpackage
